// ---- hdl/ssc_consts.svh ----
// Constants for the switch port statistics counter bank.
// Assumes byte-wide indirect register access from the host side.
// Contract
// - Port blocks based at 0x00/0x20/0x40/0x60/0x80
// - Event result: count 29:0, 36:30 zero
// - Bit 38 reports counter overflow
// - Bit 37 reports count valid
// - Shared area 0x100-0x113, four per port
// - Rx bytes all octets; Tx good only
// - Drop counters count resource discards per direction
// - Byte result: count 35:0, bit 36 zero
// - Drop result: count 15:0, 36:16 zero
// - Per-port counters clear on read
// - Global control flushes or freezes per port
// - 36 counters per port, indirect only
// - Result bytes MSB first, 116 to 120
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

`define SSC_REG_GLOBAL_CTRL 8'h08
`define SSC_REG_IND_CTRL 8'h6E
`define SSC_REG_IND_INDEX 8'h6F
`define SSC_REG_RESULT_B4 8'h74
`define SSC_REG_RESULT_B3 8'h75
`define SSC_REG_RESULT_B2 8'h76
`define SSC_REG_RESULT_B1 8'h77
`define SSC_REG_RESULT_B0 8'h78
`define SSC_SEL_PORT 8'h1C
`define SSC_SEL_SHARED 8'h1D
`define SSC_PORT_AREA_END 9'h0A0
`define SSC_SHARED_BASE 9'h100
`define SSC_SHARED_LAST 9'h113
`define SSC_GC_FLUSH_BIT 5
`define SSC_GC_FREEZE_BIT 6
`define SSC_EVT_W 30
`define SSC_BYTE_W 36
`define SSC_DROP_W 16
`define SSC_OCTET_INC_W 4
`define SSC_PORTS 5
`define SSC_EVT_PER_PORT 32

`endif

// ---- hdl/ssc_counter.sv ----
// One statistics counter with sticky overflow, clear and freeze.
// Assumes clear is a synchronous single-cycle control and freeze a synchronous held level.
`timescale 1ns/1ps
`default_nettype none
module ssc_counter #(
    parameter int W = 30,
    parameter int IW = 1
) (
    input wire logic clock_in, // Core clock
    input wire logic rst_in, // Async reset, high
    input wire logic [IW-1:0] inc_in, // Amount to add this cycle
    input wire logic clear_in, // Read clear or flush
    input wire logic freeze_in, // Hold count
    output logic [W-1:0] cnt_out, // Current count
    output logic ovf_out // Sticky overflow
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic ovf_ff;
    logic nxt_ovf;
    logic [W:0] sum;

    // Clear then add, so an event in the clearing cycle is kept unless frozen
    always_comb begin
        sum = {1'b0, cnt_ff} + {{(W + 1 - IW){1'b0}}, inc_in};
        nxt_cnt = cnt_ff;
        nxt_ovf = ovf_ff;
        if (clear_in) begin
            nxt_cnt = freeze_in ? '0 : sum[W-1:0] - cnt_ff;
            nxt_ovf = 1'b0;
        end else if (!freeze_in) begin
            nxt_cnt = sum[W-1:0];
            nxt_ovf = ovf_ff | sum[W];
        end
    end

    // Count register
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_ff <= '0;
            ovf_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            ovf_ff <= nxt_ovf;
        end
    end

    assign cnt_out = cnt_ff;
    assign ovf_out = ovf_ff;
endmodule
`default_nettype wire

// ---- hdl/ssc_counter_bank.sv ----
// Statistics counter bank for a five-port switch, host indirect access.
// Assumes host byte register port and event strobes on the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_consts.svh"
module ssc_counter_bank
    import ssc_pkg::*;
#(
    parameter int PORTS = `SSC_PORTS,
    parameter int EVTS = `SSC_EVT_PER_PORT
) (
    input wire logic clock_in, // Core clock, 25 MHz
    input wire logic rst_in, // Async reset, high
    input wire logic reg_wr_in, // Host byte write strobe
    input wire logic [7:0] reg_addr_in, // Host register number
    input wire logic [7:0] reg_wdata_in, // Host write byte
    output logic [7:0] reg_rdata_out, // Read byte, one cycle after addr
    input wire logic [PORTS-1:0][EVTS-1:0] port_evt_in, // Event strobes
    input wire logic [PORTS-1:0][3:0] rx_octets_in, // Rx octets, all
    input wire logic [PORTS-1:0][3:0] tx_octets_in, // Tx good octets
    input wire logic [PORTS-1:0] rx_drop_in, // Rx resource discard
    input wire logic [PORTS-1:0] tx_drop_in // Tx resource discard
);
    // Every concurrent check runs on the core clock, idle in reset
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    ////////////////////////////////////////////////////////////////////////
    // Host registers
    logic [7:0] ind_ctrl_ff, nxt_ind_ctrl;
    logic [7:0] ind_index_ff, nxt_ind_index;
    logic [6:0] gctrl_ff, nxt_gctrl;
    ssc_result_s result_ff, nxt_result;
    logic [7:0] rdata_ff, nxt_rdata;
    logic trig;
    logic [8:0] idx;
    ssc_area_e area;
    logic [2:0] sel_port;
    logic [4:0] sel_off;
    logic [1:0] sel_kind;
    logic [PORTS-1:0] flush_now;
    logic [PORTS-1:0] freeze_p;

    // Counter state
    logic [PORTS-1:0][EVTS-1:0][`SSC_EVT_W-1:0] evt_cnt;
    logic [PORTS-1:0][EVTS-1:0] evt_ovf;
    logic [PORTS-1:0][EVTS-1:0] evt_clr;
    logic [PORTS-1:0][`SSC_BYTE_W-1:0] rxb_cnt, txb_cnt;
    logic [PORTS-1:0][`SSC_DROP_W-1:0] rxd_cnt, txd_cnt;
    logic [PORTS-1:0] rxb_ovf, txb_ovf, rxd_ovf, txd_ovf;

    // Writing the index register is what launches a read
    assign trig = reg_wr_in && (reg_addr_in == `SSC_REG_IND_INDEX);
    assign idx = {ind_ctrl_ff[0], reg_wdata_in};

    // Index decode; the selector picks the area
    always_comb begin
        area = SSC_AREA_NONE;
        if (ind_ctrl_ff == `SSC_SEL_PORT && idx < `SSC_PORT_AREA_END) begin
            area = SSC_AREA_PORT;
        end else if (ind_ctrl_ff == `SSC_SEL_SHARED &&
                     idx >= `SSC_SHARED_BASE &&
                     idx <= `SSC_SHARED_LAST) begin
            area = SSC_AREA_SHARED;
        end
        sel_port = (area == SSC_AREA_PORT) ? idx[7:5] : idx[4:2];
        sel_off = idx[4:0];
        sel_kind = idx[1:0];
    end

    // Flush acts in the write cycle; freeze is held in the register
    always_comb begin
        for (int p = 0; p < PORTS; p++) begin
            flush_now[p] = reg_wr_in &&
                (reg_addr_in == `SSC_REG_GLOBAL_CTRL) &&
                reg_wdata_in[`SSC_GC_FLUSH_BIT] && reg_wdata_in[p];
            freeze_p[p] = gctrl_ff[`SSC_GC_FREEZE_BIT] && gctrl_ff[p];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counters: one instance per event, per port
    genvar gp, gc;
    generate
        for (gp = 0; gp < PORTS; gp++) begin : g_port
            for (gc = 0; gc < EVTS; gc++) begin : g_evt
                // Read clear only on the counter that was selected
                assign evt_clr[gp][gc] = flush_now[gp] ||
                    (trig && area == SSC_AREA_PORT &&
                     sel_port == 3'(gp) && sel_off == 5'(gc));
                ssc_counter #(.W(`SSC_EVT_W), .IW(1)) u_evt (
                    .clock_in(clock_in),
                    .rst_in(rst_in),
                    .inc_in(port_evt_in[gp][gc]),
                    .clear_in(evt_clr[gp][gc]),
                    .freeze_in(freeze_p[gp]),
                    .cnt_out(evt_cnt[gp][gc]),
                    .ovf_out(evt_ovf[gp][gc])
                );
            end
            // Shared counters keep running; only a flush clears them
            ssc_counter #(.W(`SSC_BYTE_W), .IW(`SSC_OCTET_INC_W)) u_rxb (
                .clock_in(clock_in), .rst_in(rst_in),
                .inc_in(rx_octets_in[gp]),
                .clear_in(flush_now[gp]), .freeze_in(freeze_p[gp]),
                .cnt_out(rxb_cnt[gp]), .ovf_out(rxb_ovf[gp])
            );
            ssc_counter #(.W(`SSC_BYTE_W), .IW(`SSC_OCTET_INC_W)) u_txb (
                .clock_in(clock_in), .rst_in(rst_in),
                .inc_in(tx_octets_in[gp]),
                .clear_in(flush_now[gp]), .freeze_in(freeze_p[gp]),
                .cnt_out(txb_cnt[gp]), .ovf_out(txb_ovf[gp])
            );
            ssc_counter #(.W(`SSC_DROP_W), .IW(1)) u_rxd (
                .clock_in(clock_in), .rst_in(rst_in),
                .inc_in(rx_drop_in[gp]),
                .clear_in(flush_now[gp]), .freeze_in(freeze_p[gp]),
                .cnt_out(rxd_cnt[gp]), .ovf_out(rxd_ovf[gp])
            );
            ssc_counter #(.W(`SSC_DROP_W), .IW(1)) u_txd (
                .clock_in(clock_in), .rst_in(rst_in),
                .inc_in(tx_drop_in[gp]),
                .clear_in(flush_now[gp]), .freeze_in(freeze_p[gp]),
                .cnt_out(txd_cnt[gp]), .ovf_out(txd_ovf[gp])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Register next values; counters only visible indirectly
    always_comb begin
        nxt_ind_ctrl = ind_ctrl_ff;
        nxt_ind_index = ind_index_ff;
        nxt_gctrl = gctrl_ff;
        nxt_result = result_ff;
        if (reg_wr_in) begin
            case (reg_addr_in)
                `SSC_REG_IND_CTRL: nxt_ind_ctrl = reg_wdata_in;
                `SSC_REG_IND_INDEX: nxt_ind_index = reg_wdata_in;
                `SSC_REG_GLOBAL_CTRL: nxt_gctrl = reg_wdata_in[6:0];
                default: nxt_gctrl = gctrl_ff;
            endcase
        end
        // Flush is a command, not a stored state
        nxt_gctrl[`SSC_GC_FLUSH_BIT] = 1'b0;
        if (trig) begin
            nxt_result = '0; // Reserved bits stay zero
            case (area)
                SSC_AREA_PORT: begin
                    nxt_result.value[`SSC_EVT_W-1:0] =
                        evt_cnt[sel_port][sel_off];
                    nxt_result.ovf = evt_ovf[sel_port][sel_off];
                    nxt_result.valid = 1'b1;
                end
                SSC_AREA_SHARED: begin
                    nxt_result.valid = 1'b1;
                    case (sel_kind)
                        2'h0: begin
                            nxt_result.value[`SSC_BYTE_W-1:0] =
                                rxb_cnt[sel_port];
                            nxt_result.ovf = rxb_ovf[sel_port];
                        end
                        2'h1: begin
                            nxt_result.value[`SSC_BYTE_W-1:0] =
                                txb_cnt[sel_port];
                            nxt_result.ovf = txb_ovf[sel_port];
                        end
                        2'h2: begin
                            nxt_result.value[`SSC_DROP_W-1:0] =
                                rxd_cnt[sel_port];
                            nxt_result.ovf = rxd_ovf[sel_port];
                        end
                        default: begin
                            nxt_result.value[`SSC_DROP_W-1:0] =
                                txd_cnt[sel_port];
                            nxt_result.ovf = txd_ovf[sel_port];
                        end
                    endcase
                end
                default: nxt_result = '0; // Bad index reads as not valid
            endcase
        end
    end

    // Read byte mux, registered so the data output is a flop
    always_comb begin
        case (reg_addr_in)
            `SSC_REG_GLOBAL_CTRL: nxt_rdata = {1'b0, gctrl_ff};
            `SSC_REG_IND_CTRL: nxt_rdata = ind_ctrl_ff;
            `SSC_REG_IND_INDEX: nxt_rdata = ind_index_ff;
            `SSC_REG_RESULT_B4: nxt_rdata = result_ff[39:32];
            `SSC_REG_RESULT_B3: nxt_rdata = result_ff[31:24];
            `SSC_REG_RESULT_B2: nxt_rdata = result_ff[23:16];
            `SSC_REG_RESULT_B1: nxt_rdata = result_ff[15:8];
            `SSC_REG_RESULT_B0: nxt_rdata = result_ff[7:0];
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Register stage
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ind_ctrl_ff <= 8'h00;
            ind_index_ff <= 8'h00;
            gctrl_ff <= 7'h00;
            result_ff <= '0;
            rdata_ff <= 8'h00;
        end else begin
            ind_ctrl_ff <= nxt_ind_ctrl;
            ind_index_ff <= nxt_ind_index;
            gctrl_ff <= nxt_gctrl;
            result_ff <= nxt_result;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_out = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic trig_sel_port, trig_sel_shared;
    assign trig_sel_port = trig && ind_ctrl_ff == `SSC_SEL_PORT;
    assign trig_sel_shared = trig && ind_ctrl_ff == `SSC_SEL_SHARED;

    a_port2_base_map: assert property (
        trig_sel_port && reg_wdata_in == 8'h25 |=>
        result_ff.value[29:0] == $past(evt_cnt[1][5]) && result_ff.valid)
        else $error("port 2 offset 0x5 not mapped at 0x25");
    a_port1_base_map: assert property (
        trig_sel_port && reg_wdata_in == 8'h00 |=>
        result_ff.value[29:0] == $past(evt_cnt[0][0]))
        else $error("port 1 offset 0x0 not mapped at 0x00");
    a_evt_reserved_zero: assert property (
        trig_sel_port |=> result_ff.value[36:30] == 7'h00)
        else $error("event result reserved bits not zero");
    a_ovf_reported: assert property (
        trig_sel_port && reg_wdata_in == 8'h00 |=>
        result_ff.ovf == $past(evt_ovf[0][0]))
        else $error("overflow flag not carried into result");
    a_valid_reported: assert property (
        (trig_sel_port && reg_wdata_in < 8'hA0) or
        (trig_sel_shared && reg_wdata_in < 8'h14 && ind_ctrl_ff[0])
        |=> result_ff.valid)
        else $error("valid flag not set on good read");
    a_shared_map: assert property (
        trig_sel_shared && reg_wdata_in == 8'h05 |=>
        result_ff.value[35:0] == $past(txb_cnt[1]))
        else $error("0x105 is not port 2 tx bytes");
    a_rx_bytes_add: assert property (
        !flush_now[0] && !freeze_p[0] && !rxb_ovf[0] |=>
        rxb_ovf[0] || rxb_cnt[0] ==
        $past(rxb_cnt[0]) + 36'($past(rx_octets_in[0])))
        else $error("rx byte counter missed octets");
    a_tx_drop_add: assert property (
        tx_drop_in[2] && !flush_now[2] && !freeze_p[2] |=>
        txd_cnt[2] == $past(txd_cnt[2]) + 16'h0001)
        else $error("tx drop counter missed a discard");
    a_byte_reserved_zero: assert property (
        trig_sel_shared && reg_wdata_in[1] == 1'b0 |=>
        result_ff.value[36] == 1'b0)
        else $error("byte result bit 36 not zero");
    a_drop_reserved_zero: assert property (
        trig_sel_shared && reg_wdata_in[1] == 1'b1 |=>
        result_ff.value[36:16] == 21'h000000)
        else $error("drop result reserved bits not zero");
    a_read_clears: assert property (
        trig_sel_port && reg_wdata_in == 8'h00 && !port_evt_in[0][0] |=>
        evt_cnt[0][0] == 30'h00000000 ##1 result_ff.valid)
        else $error("per-port counter not cleared by read");
    a_freeze_holds: assert property (
        freeze_p[1] && !evt_clr[1][5] |=> $stable(evt_cnt[1][5]))
        else $error("frozen counter moved");
    a_ovf_sticky: assert property (
        txd_ovf[0] && !flush_now[0] |=> txd_ovf[0])
        else $error("overflow flag dropped without clear");
    a_result_msb_byte: assert property (
        reg_addr_in == `SSC_REG_RESULT_B4 && !trig |=>
        reg_rdata_out == result_ff[39:32])
        else $error("register 116 does not hold bits 39:32");

    c_port_read: cover property (trig_sel_port ##1 result_ff.valid);
    c_shared_read: cover property (trig_sel_shared ##1 result_ff.valid);
    c_flush: cover property (flush_now[0] ##1 evt_cnt[0][0] == '0);
    c_frozen: cover property (freeze_p[1] && port_evt_in[1][5]);
endmodule
`default_nettype wire

// ---- hdl/ssc_pkg.sv ----
// Types shared by the statistics counter bank.
// Assumes ssc_consts.svh supplies the numbers.
package ssc_pkg;
    // Area that an indirect index falls into
    typedef enum logic [2:0] {
        SSC_AREA_NONE = 3'b001,
        SSC_AREA_PORT = 3'b010,
        SSC_AREA_SHARED = 3'b100
    } ssc_area_e;

    // Indirect read result word, bit 39 down to bit 0
    typedef struct packed {
        logic spare;
        logic ovf;
        logic valid;
        logic [36:0] value;
    } ssc_result_s;
endpackage

// ---- tb/ssc_host_model.sv ----
// Host model: drives the bank's byte register port like a processor.
// Assumes one access at a time, started by a one-cycle req_in.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_consts.svh"
module ssc_host_model
    import ssc_pkg::*;
(
    input wire logic clock_in, // Core clock
    input wire logic rst_in, // Async reset, high
    input wire logic req_in, // Start one access
    input wire logic wr_only_in, // Plain write, no readback
    input wire logic [7:0] sel_in, // Selector or register
    input wire logic [7:0] idx_in, // Index or write byte
    input wire logic [7:0] reg_rdata_in, // Byte from the bank
    output logic reg_wr_out, // Write strobe
    output logic [7:0] reg_addr_out, // Register number
    output logic [7:0] reg_wdata_out, // Write byte
    output logic busy_out, // Access in progress
    output logic done_out, // Result strobe, one cycle
    output ssc_result_s result_out // Assembled result word
);
    logic [39:0] acc;
    logic [7:0] s_q;
    logic [7:0] i_q;

    // One byte write, held until the edge that takes it
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        reg_wr_out <= 1'b1;
        reg_addr_out <= a;
        reg_wdata_out <= d;
        @(posedge clock_in);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Accesses run back to back
    initial begin
        reg_wr_out = 1'b0;
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
        busy_out = 1'b0;
        done_out = 1'b0;
        result_out = '0;
        acc = '0;
        forever begin
            @(posedge clock_in);
            done_out <= 1'b0;
            if (req_in === 1'b1 && rst_in === 1'b0) begin
                s_q = sel_in;
                i_q = idx_in;
                busy_out <= 1'b1;
                if (wr_only_in) begin
                    put(s_q, i_q);
                end else begin
                    put(`SSC_REG_IND_CTRL, s_q);
                    put(`SSC_REG_IND_INDEX, i_q);
                    reg_wr_out <= 1'b0;
                    // Read data lags the address by one cycle
                    for (int k = 0; k < 5; k++) begin
                        reg_addr_out <= `SSC_REG_RESULT_B4 + 8'(k);
                        repeat (2) @(posedge clock_in);
                        acc = {acc[31:0], reg_rdata_in};
                    end
                    result_out <= acc;
                    done_out <= 1'b1;
                end
                reg_wr_out <= 1'b0;
                busy_out <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/switch_port_statistics_counters_tb.sv ----
// Self-checking bench for the statistics counter bank.
// Assumes the host model drives the register port at 25 MHz.
`timescale 1ns/1ps
`default_nettype none
module switch_port_statistics_counters_tb;
    import ssc_pkg::*;
    logic clock_in, rst_in, req, wr_only, reg_wr, busy, done;
    logic [7:0] sel, idx, reg_addr, reg_wdata, reg_rdata;
    ssc_result_s res;
    logic [4:0][31:0] evt;
    logic [4:0][3:0] rxo, txo;
    logic [4:0] rxd, txd;
    logic [39:0] exp_q[$];
    logic [39:0] e;
    logic [36:0] s[4];
    logic [3:0] r, t;
    logic da, db;
    int bad_count, cmp_count, n, o;

    ssc_counter_bank u_dut (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .reg_wr_in(reg_wr),
        .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata),
        .reg_rdata_out(reg_rdata),
        .port_evt_in(evt),
        .rx_octets_in(rxo),
        .tx_octets_in(txo),
        .rx_drop_in(rxd),
        .tx_drop_in(txd)
    );

    ssc_host_model u_host (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .req_in(req),
        .wr_only_in(wr_only),
        .sel_in(sel),
        .idx_in(idx),
        .reg_rdata_in(reg_rdata),
        .reg_wr_out(reg_wr),
        .reg_addr_out(reg_addr),
        .reg_wdata_out(reg_wdata),
        .busy_out(busy),
        .done_out(done),
        .result_out(res)
    );

    // 40 ns core clock
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end

    task automatic final_report();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One host access; a hung host ends the run
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [7:0] d);
        int k;
        req <= 1'b1;
        wr_only <= w;
        sel <= a;
        idx <= d;
        @(posedge clock_in);
        req <= 1'b0;
        for (k = 0; k < 60; k++) begin
            @(posedge clock_in);
            if (busy === 1'b0) break;
        end
        if (k == 60) begin
            bad_count++;
            $display("unexpected timeout at %0t: got %h exp %h",
                     $time, busy, 1'b0);
            final_report();
        end
    endtask

    // Note the expected word, then trigger and read back
    task automatic rd(input logic [7:0] a, input logic [7:0] d,
                      input logic [39:0] x);
        exp_q.push_back(x);
        access(1'b0, a, d);
    endtask

    function automatic logic [39:0] word(input logic v, input logic [36:0] c);
        return {1'b0, v, 1'b1, c};
    endfunction

    // Hold the event inputs for c edges, then drop them all
    task automatic run(input int c);
        repeat (c) @(posedge clock_in);
        evt <= '0;
        rxo <= '0;
        txo <= '0;
        rxd <= '0;
        txd <= '0;
        @(posedge clock_in);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Oldest note against each result; an empty queue gives X
    always @(posedge clock_in) begin
        if (done === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 40'hX;
            cmp_count++;
            if (res !== e) begin
                bad_count++;
                $display("unexpected word at %0t: got %h exp %h",
                         $time, res, e);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        rst_in = 1'b1;
        req = 1'b0;
        wr_only = 1'b0;
        sel = 8'h00;
        idx = 8'h00;
        evt = '0;
        rxo = '0;
        txo = '0;
        rxd = '0;
        txd = '0;
        bad_count = 0;
        cmp_count = 0;
        void'($urandom(32'hF64ABE9D));
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        // Every port block, first and last offsets included; then cleared
        for (int p = 0; p < 5; p++) begin
            o = (p == 0) ? 0 : (p == 4) ? 31 : int'($urandom % 32);
            n = 1 + int'($urandom % 20);
            evt[p][o] <= 1'b1;
            run(n);
            rd(8'h1C, 8'(p * 32 + o), word(1'b0, 37'(n)));
            rd(8'h1C, 8'(p * 32 + o), word(1'b0, 37'h0));
        end
        // Shared totals under random traffic; not cleared by reading
        for (int p = 0; p < 5; p++) begin
            s = '{default: '0};
            for (int c = 0; c < 8; c++) begin
                r = 4'($urandom);
                t = 4'($urandom);
                da = 1'($urandom);
                db = 1'($urandom);
                rxo[p] <= r;
                txo[p] <= t;
                rxd[p] <= da;
                txd[p] <= db;
                s[0] += 37'(r);
                s[1] += 37'(t);
                s[2] += 37'(da);
                s[3] += 37'(db);
                @(posedge clock_in);
            end
            run(0);
            for (int k = 0; k < 4; k++) begin
                rd(8'h1D, 8'(p*4+k), word(1'b0, s[k]));
            end
            rd(8'h1D, 8'(p * 4), word(1'b0, s[0]));
        end
        // Flush port 2 only; port 3 keeps its count
        evt[1][5] <= 1'b1;
        evt[2][5] <= 1'b1;
        rxd[1] <= 1'b1;
        run(4);
        access(1'b1, 8'h08, 8'h22);
        rd(8'h1C, 8'h25, word(1'b0, 37'h0));
        rd(8'h1D, 8'h06, word(1'b0, 37'h0));
        rd(8'h1C, 8'h45, word(1'b0, 37'h4));
        // Freeze port 2, then release it
        access(1'b1, 8'h08, 8'h42);
        evt[1][5] <= 1'b1;
        run(3);
        rd(8'h1C, 8'h25, word(1'b0, 37'h0));
        access(1'b1, 8'h08, 8'h00);
        evt[1][5] <= 1'b1;
        run(2);
        rd(8'h1C, 8'h25, word(1'b0, 37'h2));
        // Discard counter wraps; flag sticks until a flush
        access(1'b1, 8'h08, 8'h21);
        txd[0] <= 1'b1;
        run(65537);
        rd(8'h1D, 8'h03, word(1'b1, 37'h1));
        rd(8'h1D, 8'h03, word(1'b1, 37'h1));
        access(1'b1, 8'h08, 8'h21);
        rd(8'h1D, 8'h03, word(1'b0, 37'h0));
        // Out of range indices and a foreign selector
        rd(8'h1C, 8'hA0, 40'h0);
        rd(8'h1D, 8'h14, 40'h0);
        rd(8'h1E, 8'h00, 40'h0);
        @(posedge clock_in);
        if (exp_q.size() != 0) begin
            bad_count++;
            $display("unexpected leftover at %0t: got %h exp %h",
                     $time, exp_q.size(), 0);
        end
        final_report();
    end
endmodule
`default_nettype wire
